// ### rtl/mhp_pkg.sv
// Constants shared by the modem host register port and its serial engine.
// Assumes a single 125 MHz system clock and synchronous reset.
package mhp_pkg;
  // Register addresses
  localparam logic [2:0] ADDR_LINE_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_HOST_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_DETECT_STATUS = 3'h2;
  localparam logic [2:0] ADDR_TONE_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_RSVD_CONTROL_A = 3'h4;
  localparam logic [2:0] ADDR_RSVD_CONTROL_B = 3'h5;
  localparam logic [2:0] ADDR_PART_CODE = 3'h6;
  // Reset values; part code is arbitrary
  localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
  localparam logic [7:0] PART_CODE_VAL = 8'h5a;
  // Field positions
  localparam int LC_TXMODE_LSB = 2;
  localparam int LC_FSK_BIT = 5;
  localparam int LC_RATE600_BIT = 7;
  localparam int HC_SRST_BIT = 2;
  localparam int HC_CLK_CTRL_BIT = 3;
  localparam int HC_INT_EN_BIT = 5;
  localparam int DET_CARRIER_BIT = 3;
  // Transmit timing modes
  localparam logic [3:0] TXM_POWER_DOWN = 4'h0;
  localparam logic [3:0] TXM_EXT_SYNC = 4'h2;
  localparam logic [3:0] TXM_SLAVE = 4'h3;
  // Synchroniser vector layout and idle value
  localparam int SY_SERIAL = 15;
  localparam int SY_ALE = 14;
  localparam int SY_CS_N = 13;
  localparam int SY_RD_N = 12;
  localparam int SY_WR_N = 11;
  localparam int SY_EXT = 10;
  localparam int SY_SDATA = 9;
  localparam int SY_TXD = 8;
  localparam logic [15:0] SYNC_IDLE = 16'h7d00;
  // Clock output timing
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int XTAL_HZ = 11_059_200;
  localparam int DATA_RATE_HZ = 1200;
  localparam int XTAL_HALF_CYC = SYS_CLK_HZ / (2 * XTAL_HZ);
  localparam int BAUD16_HALF_CYC = SYS_CLK_HZ / (2 * 16 * DATA_RATE_HZ);
  localparam logic [12:0] XTAL_HALF_CNT = 13'(XTAL_HALF_CYC - 1);
  localparam logic [12:0] BAUD16_HALF_CNT = 13'(BAUD16_HALF_CYC - 1);
  localparam logic [12:0] BAUD16_HALF600_CNT = 13'(2 * BAUD16_HALF_CYC - 1);
  // Serial engine states
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_IN = 2'b01, S_OUT = 2'b11} mhp_ser_st_e;
endpackage : mhp_pkg

// ### rtl/mhp_ser_if.sv
// Link between the register port and its serial command engine.
// Assumes both ends run on the system clock; pulses last one cycle.
`timescale 1ns/1ns
interface mhp_ser_if;
  logic en;
  logic ext_fall;
  logic rd_fall;
  logic wr_rise;
  logic rd_n;
  logic din;
  logic [7:0] rdata;
  logic dout;
  logic oe_n;
  logic wr_stb;
  logic [7:0] wdata;
  modport host (output en, ext_fall, rd_fall, wr_rise, rd_n, din, rdata, input dout, oe_n, wr_stb, wdata);
  modport port (input en, ext_fall, rd_fall, wr_rise, rd_n, din, rdata, output dout, oe_n, wr_stb, wdata);
endinterface : mhp_ser_if

// ### rtl/mhp_serial_port.sv
// Serial command engine: shifts register data in and out on external clock falls.
// Assumes synchronised pins and edge pulses from the register port.
`timescale 1ns/1ns
module mhp_serial_port
  import mhp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  mhp_ser_if.port sp
);
  mhp_ser_st_e st_q, st_d;
  logic [7:0] sh_q, sh_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    if (!sp.en) begin
      st_d = S_IDLE;
    end else if (sp.rd_fall) begin
      sh_d = sp.rdata;
      st_d = S_OUT;
    end else if (st_q == S_OUT) begin
      if (sp.rd_n) begin
        st_d = S_IN;
      end else if (sp.ext_fall) begin
        sh_d = {1'b0, sh_q[7:1]};
      end
    end else begin
      st_d = S_IN;
      if (sp.ext_fall && sp.rd_n) begin
        sh_d = {sp.din, sh_q[7:1]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      sh_q <= CTRL_RESET_VAL;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
    end
  end

  assign sp.dout = sh_q[0];
  assign sp.oe_n = ~(sp.en && st_q == S_OUT && !sp.rd_n);
  assign sp.wr_stb = sp.en && sp.wr_rise && sp.rd_n;
  assign sp.wdata = sh_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ser_shift_out_a: assert property (st_q == S_OUT && !sp.rd_n && !sp.rd_fall && sp.ext_fall
    |=> sp.dout == $past(sh_q[1])) else $error("Serial read bit order wrong");
  ser_shift_in_a: assert property ((st_q != S_OUT) && sp.en && sp.rd_n && sp.ext_fall && !sp.rd_fall
    |=> sh_q[7] == $past(sp.din)) else $error("Serial write bit not captured");
  ser_read_cv: cover property (sp.rd_fall ##1 (st_q == S_OUT && !sp.oe_n));
endmodule : mhp_serial_port

// ### rtl/mhp_host_port.sv
// Modem host register port: parallel and serial register access, clock and data pins.
// Assumes the modem core supplies detect status, receive clock and data on SYS_CLK_I.
`timescale 1ns/1ns
module mhp_host_port
  import mhp_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic SERIAL_MODE_I,
  input wire logic ALE_I,
  input wire logic CS_N_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic [7:0] MUXED_BUS_LINES_I,
  output logic [7:0] MUXED_BUS_LINES_O,
  output logic MUXED_BUS_LINES_OE_N_O,
  input wire logic SER_DATA_I,
  output logic SER_DATA_O,
  output logic SER_DATA_OE_N_O,
  input wire logic EXT_TIMING_CLOCK_I,
  input wire logic TXD_I,
  output logic TX_BIT_CLOCK_O,
  output logic TX_DATA_O,
  output logic TX_DATA_STB_O,
  input wire logic [5:0] DET_STATUS_I,
  input wire logic RX_CLK_CORE_I,
  input wire logic RX_DATA_CORE_I,
  output logic RX_BIT_CLOCK_O,
  output logic RXD_O,
  output logic INT_O,
  output logic INT_OE_N_O,
  output logic CLK_O,
  output logic [7:0] LINE_CONTROL_O,
  output logic [7:0] TONE_CONTROL_O,
  output logic ANSWER_MODE_O
);
  import mhp_pkg::*;

  function automatic logic fell(input logic now, input logic was);
    return was & ~now;
  endfunction : fell

  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction : rose

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [15:0] s1_q, s2_q, p_q;
  logic serial, ale_fall, rd_fall, wr_rise, ext_fall, ext_rise;
  logic [7:0] bus_s, bus_p;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      p_q <= SYNC_IDLE;
    end else begin
      s1_q <= {SERIAL_MODE_I, ALE_I, CS_N_I, RD_N_I, WR_N_I, EXT_TIMING_CLOCK_I, SER_DATA_I, TXD_I, MUXED_BUS_LINES_I};
      s2_q <= s1_q;
      p_q <= s2_q;
    end
  end

  assign serial = s2_q[SY_SERIAL];
  assign bus_s = s2_q[7:0];
  assign bus_p = p_q[7:0];
  assign ale_fall = fell(s2_q[SY_ALE], p_q[SY_ALE]);
  assign rd_fall = fell(s2_q[SY_RD_N], p_q[SY_RD_N]);
  assign wr_rise = rose(s2_q[SY_WR_N], p_q[SY_WR_N]);
  assign ext_fall = fell(s2_q[SY_EXT], p_q[SY_EXT]);
  assign ext_rise = rose(s2_q[SY_EXT], p_q[SY_EXT]);

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  logic [2:0] alat_q, alat_d;
  logic cs_lat_q, cs_lat_d;
  logic [7:0] lc_q, lc_d, hc_q, hc_d, tc_q, tc_d, bus_o_q, bus_o_d;
  logic [5:0] det_q, det_d;
  logic irq_q, irq_d;
  logic par_wr, par_rd, wr_en, rd_det, det_chg;
  logic [2:0] waddr;
  logic [7:0] wdata;
  mhp_ser_if sif ();

  function automatic logic [7:0] rd_mux(input logic [2:0] a, input logic [7:0] lc, input logic [7:0] hc,
                                        input logic [5:0] det, input logic [7:0] tc);
    if (a == ADDR_LINE_CONTROL) begin
      return lc;
    end else if (a == ADDR_HOST_CONTROL) begin
      return hc;
    end else if (a == ADDR_DETECT_STATUS) begin
      return {2'h0, det};
    end else if (a == ADDR_TONE_CONTROL) begin
      return tc;
    end else if (a == ADDR_PART_CODE) begin
      return PART_CODE_VAL;
    end else begin
      return 8'h00;
    end
  endfunction : rd_mux

  assign par_wr = !serial && cs_lat_q && wr_rise;
  assign par_rd = !serial && cs_lat_q && rd_fall;
  assign wr_en = par_wr || sif.wr_stb;
  assign waddr = serial ? bus_s[2:0] : alat_q;
  assign wdata = serial ? sif.wdata : bus_p;
  assign rd_det = (par_rd && alat_q == ADDR_DETECT_STATUS) || (serial && rd_fall && bus_s[2:0] == ADDR_DETECT_STATUS);
  assign det_chg = det_q[4:1] != DET_STATUS_I[4:1];

  always_comb begin
    alat_d = alat_q;
    cs_lat_d = cs_lat_q;
    lc_d = lc_q;
    hc_d = hc_q;
    tc_d = tc_q;
    det_d = DET_STATUS_I;
    irq_d = irq_q;
    if (ale_fall) begin
      alat_d = bus_s[2:0];
      cs_lat_d = !s2_q[SY_CS_N];
    end
    if (hc_q[HC_SRST_BIT]) begin
      lc_d = CTRL_RESET_VAL;
      hc_d = CTRL_RESET_VAL;
      tc_d = CTRL_RESET_VAL;
    end else if (wr_en) begin
      if (waddr == ADDR_LINE_CONTROL) begin
        lc_d = wdata;
      end else if (waddr == ADDR_HOST_CONTROL) begin
        hc_d = wdata;
      end else if (waddr == ADDR_TONE_CONTROL) begin
        tc_d = wdata;
      end
    end
    if (det_chg && hc_q[HC_INT_EN_BIT]) begin
      irq_d = 1'b1;
    end else if (rd_det) begin
      irq_d = 1'b0;
    end
    bus_o_d = rd_mux(alat_q, lc_q, hc_q, det_q, tc_q);
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      alat_q <= 3'h0;
      cs_lat_q <= 1'b0;
      lc_q <= CTRL_RESET_VAL;
      hc_q <= CTRL_RESET_VAL;
      tc_q <= CTRL_RESET_VAL;
      det_q <= 6'h00;
      irq_q <= 1'b0;
      bus_o_q <= 8'h00;
    end else begin
      alat_q <= alat_d;
      cs_lat_q <= cs_lat_d;
      lc_q <= lc_d;
      hc_q <= hc_d;
      tc_q <= tc_d;
      det_q <= det_d;
      irq_q <= irq_d;
      bus_o_q <= bus_o_d;
    end
  end

  assign MUXED_BUS_LINES_O = bus_o_q;
  assign MUXED_BUS_LINES_OE_N_O = ~(!serial && cs_lat_q && !s2_q[SY_RD_N]);
  assign INT_O = 1'b0;
  assign INT_OE_N_O = ~irq_q;
  assign LINE_CONTROL_O = lc_q;
  assign TONE_CONTROL_O = tc_q;
  assign ANSWER_MODE_O = !lc_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Serial command engine
  assign sif.en = serial;
  assign sif.ext_fall = ext_fall;
  assign sif.rd_fall = rd_fall;
  assign sif.wr_rise = wr_rise;
  assign sif.rd_n = s2_q[SY_RD_N];
  assign sif.din = s2_q[SY_SDATA];
  assign sif.rdata = rd_mux(bus_s[2:0], lc_q, hc_q, det_q, tc_q);

  mhp_serial_port u_ser (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .sp(sif.port)
  );

  assign SER_DATA_O = sif.dout;
  assign SER_DATA_OE_N_O = sif.oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Clocks and data pins
  logic [12:0] xcnt_q, xcnt_d, bcnt_q, bcnt_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic xclk_q, xclk_d, bclk_q, bclk_d, txc_q, txc_d, txd_q, txd_d, stb_q, stb_d;
  logic rxc_q, rxc_d, rxd_q, rxd_d, rxp_q, dpsk;
  logic [12:0] bhalf;
  logic [3:0] txm;

  assign txm = lc_q[LC_TXMODE_LSB +: 4];
  assign dpsk = !lc_q[LC_FSK_BIT] && txm != TXM_POWER_DOWN;
  assign bhalf = lc_q[LC_RATE600_BIT] ? BAUD16_HALF600_CNT : BAUD16_HALF_CNT;

  always_comb begin
    xcnt_d = xcnt_q + 13'h1;
    xclk_d = xclk_q;
    bcnt_d = bcnt_q + 13'h1;
    bclk_d = bclk_q;
    tcnt_d = tcnt_q;
    if (xcnt_q >= XTAL_HALF_CNT) begin
      xcnt_d = 13'h0;
      xclk_d = !xclk_q;
    end
    if (bcnt_q >= bhalf) begin
      bcnt_d = 13'h0;
      bclk_d = !bclk_q;
      tcnt_d = tcnt_q + {3'h0, !bclk_q};
    end
    if (txm == TXM_EXT_SYNC) begin
      txc_d = s2_q[SY_EXT];
    end else if (txm == TXM_SLAVE) begin
      txc_d = rxc_q;
    end else begin
      txc_d = tcnt_q[3];
    end
    txd_d = txd_q;
    stb_d = 1'b0;
    if ((txm == TXM_EXT_SYNC) ? ext_rise : rose(txc_d, txc_q)) begin
      txd_d = s2_q[SY_TXD];
      stb_d = 1'b1;
    end
    rxc_d = DET_STATUS_I[DET_CARRIER_BIT] ? RX_CLK_CORE_I : 1'b1;
    rxd_d = rxd_q;
    if (!DET_STATUS_I[DET_CARRIER_BIT]) begin
      rxd_d = 1'b1;
    end else if (fell(RX_CLK_CORE_I, rxp_q)) begin
      rxd_d = RX_DATA_CORE_I;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      xcnt_q <= 13'h0;
      xclk_q <= 1'b0;
      bcnt_q <= 13'h0;
      bclk_q <= 1'b0;
      tcnt_q <= 4'h0;
      txc_q <= 1'b0;
      txd_q <= 1'b1;
      stb_q <= 1'b0;
      rxc_q <= 1'b1;
      rxd_q <= 1'b1;
      rxp_q <= 1'b1;
    end else begin
      xcnt_q <= xcnt_d;
      xclk_q <= xclk_d;
      bcnt_q <= bcnt_d;
      bclk_q <= bclk_d;
      tcnt_q <= tcnt_d;
      txc_q <= txc_d;
      txd_q <= txd_d;
      stb_q <= stb_d;
      rxc_q <= rxc_d;
      rxd_q <= rxd_d;
      rxp_q <= RX_CLK_CORE_I;
    end
  end

  assign CLK_O = (hc_q[HC_CLK_CTRL_BIT] && dpsk) ? bclk_q : xclk_q;
  assign TX_BIT_CLOCK_O = txc_q;
  assign TX_DATA_O = txd_q;
  assign TX_DATA_STB_O = stb_q;
  assign RX_BIT_CLOCK_O = rxc_q;
  assign RXD_O = rxd_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  addr_latch_a: assert property (ale_fall |=> alat_q == $past(bus_s[2:0]) ##1 $stable(alat_q) || ale_fall)
    else $error("Address not latched on latch fall");
  unsel_quiet_a: assert property (!cs_lat_q && !serial |-> MUXED_BUS_LINES_OE_N_O)
    else $error("Bus driven while unselected");
  drive_read_a: assert property (!MUXED_BUS_LINES_OE_N_O |-> !s2_q[SY_RD_N] && cs_lat_q)
    else $error("Bus driven without read");
  store_write_a: assert property (par_wr && alat_q == ADDR_TONE_CONTROL && !hc_q[HC_SRST_BIT]
    |=> tc_q == $past(bus_p)) else $error("Tone register not stored");
  int_hold_a: assert property (irq_q && !rd_det |=> !INT_OE_N_O)
    else $error("Interrupt dropped early");
  int_set_a: assert property (det_chg && hc_q[HC_INT_EN_BIT] |=> !INT_OE_N_O [*1] ##0 irq_q)
    else $error("Interrupt not raised on detect change");
  soft_reset_a: assert property (hc_q[HC_SRST_BIT] |=> lc_q == 8'h00 && hc_q == 8'h00 && tc_q == 8'h00)
    else $error("Software reset did not clear registers");
  no_carrier_a: assert property (!DET_STATUS_I[DET_CARRIER_BIT] |=> RXD_O && RX_BIT_CLOCK_O)
    else $error("Receive data not mark without carrier");
  rsvd_write_a: assert property (wr_en && waddr[2] && !hc_q[HC_SRST_BIT]
    |=> $stable(lc_q) && $stable(hc_q) && $stable(tc_q)) else $error("Reserved write changed state");

  par_read_cv: cover property (par_rd ##1 !MUXED_BUS_LINES_OE_N_O);
  par_write_cv: cover property (par_wr && alat_q == ADDR_LINE_CONTROL);
  ser_write_cv: cover property (sif.wr_stb);
  irq_clear_cv: cover property (irq_q && rd_det ##1 !irq_q);
endmodule : mhp_host_port

// ### verif/mhp_host_model.sv
// Host processor model for the register port: parallel and serial accesses.
// Assumes pins change at the falling clock edge; each read is reported by a one-cycle strobe.
`timescale 1ns/1ns
module mhp_host_model (
  input wire logic clk_i,
  input wire logic [7:0] bus_dev_i,
  input wire logic bus_oe_n_i,
  input wire logic ser_dev_i,
  input wire logic ser_oe_n_i,
  output logic serial_mode_o,
  output logic ale_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ext_clk_o,
  output logic [7:0] bus_o,
  output logic ser_o,
  output logic got_stb_o,
  output logic [8:0] got_o
);
  logic [7:0] drv;
  logic drv_en;
  logic sdrv;
  ////////////////////////////////////////
  // Wire levels; a released bus shows the inverse of its last value
  assign bus_o = !bus_oe_n_i ? bus_dev_i : (drv_en ? drv : ~drv);
  assign ser_o = !ser_oe_n_i ? ser_dev_i : sdrv;
  initial begin
    serial_mode_o = 1'b0;
    ale_o = 1'b1;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ext_clk_o = 1'b1;
    drv = 8'h00;
    drv_en = 1'b1;
    sdrv = 1'b1;
    got_stb_o = 1'b0;
    got_o = 9'h000;
  end
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic report(input logic [8:0] v);
    got_o = v;
    got_stb_o = 1'b1;
    cyc(1);
    got_stb_o = 1'b0;
  endtask : report
  // Parallel access: latch phase, then one strobe
  task automatic par(input logic we, input logic cs_n, input logic [2:0] a, input logic [7:0] d);
    serial_mode_o = 1'b0;
    cs_n_o = cs_n;
    drv = {5'h00, a};
    drv_en = 1'b1;
    cyc(4);
    ale_o = 1'b0;
    cyc(4);
    if (we) begin
      drv = d;
      wr_n_o = 1'b0;
      cyc(4);
      wr_n_o = 1'b1;
      cyc(4);
    end else begin
      drv_en = 1'b0;
      rd_n_o = 1'b0;
      cyc(4);
      report(bus_oe_n_i ? 9'h100 : {1'b0, bus_dev_i});
      rd_n_o = 1'b1;
      cyc(3);
    end
    ale_o = 1'b1;
    drv_en = 1'b1;
  endtask : par
  // Serial access: clock stands high outside frames
  task automatic ser(input logic we, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] g;
    serial_mode_o = 1'b1;
    ale_o = 1'b1;
    cs_n_o = 1'b0;
    drv = {5'h00, a};
    drv_en = 1'b1;
    cyc(4);
    if (we) begin
      for (int i = 0; i < 8; i++) begin
        sdrv = d[i];
        cyc(2);
        ext_clk_o = 1'b0;
        cyc(4);
        ext_clk_o = 1'b1;
        cyc(4);
      end
      sdrv = ~sdrv;
      wr_n_o = 1'b0;
      cyc(4);
      wr_n_o = 1'b1;
      cyc(5);
    end else begin
      rd_n_o = 1'b0;
      cyc(4);
      g[0] = ser_dev_i;
      for (int i = 1; i < 9; i++) begin
        ext_clk_o = 1'b0;
        cyc(5);
        if (i < 8) begin
          g[i] = ser_dev_i;
        end
        ext_clk_o = 1'b1;
        cyc(4);
      end
      report({ser_oe_n_i, g});
      sdrv = ~ser_dev_i;
      rd_n_o = 1'b1;
      cyc(4);
    end
  endtask : ser
  // External timing clock level held four cycles
  task automatic ext_level(input logic v);
    ext_clk_o = v;
    cyc(4);
  endtask : ext_level
endmodule : mhp_host_model

// ### verif/test_modem_host_register_port.sv
// Self-checking bench for the modem host register port.
// Assumes the host model for pin traffic; core-side inputs are driven here.
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, sn); end end
module test_modem_host_register_port;
  import mhp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] det = 6'h00;
  logic txd = 1'b1;
  logic rxcc = 1'b0;
  logic rxdd = 1'b1;
  logic txc, txo, tx_stb;
  logic serial_mode, ale, cs_n, rd_n, wr_n, ext_clk, ser_lvl, ser_dev, ser_oe_n, bus_oe_n, got_stb;
  logic int_n, int_o, rxc, rxd, clko, ans;
  logic [7:0] bus_lvl, bus_dev, lc, tc, d, t;
  logic [7:0] shadow [8];
  logic [8:0] got, mon_exp;
  logic [8:0] exp_q [$];
  int errors = 0;
  int checks_done = 0;
  int n;
  int stb_cnt = 0;
  always #4 clk = ~clk;
  ////////////////////////////////////////
  mhp_host_port mhp_host_port_inst (.SYS_CLK_I(clk), .RST_I(rst), .SERIAL_MODE_I(serial_mode), .ALE_I(ale),
    .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n), .MUXED_BUS_LINES_I(bus_lvl), .MUXED_BUS_LINES_O(bus_dev),
    .MUXED_BUS_LINES_OE_N_O(bus_oe_n), .SER_DATA_I(ser_lvl), .SER_DATA_O(ser_dev), .SER_DATA_OE_N_O(ser_oe_n),
    .EXT_TIMING_CLOCK_I(ext_clk), .TXD_I(txd), .TX_BIT_CLOCK_O(txc), .TX_DATA_O(txo), .TX_DATA_STB_O(tx_stb),
    .DET_STATUS_I(det), .RX_CLK_CORE_I(rxcc), .RX_DATA_CORE_I(rxdd), .RX_BIT_CLOCK_O(rxc), .RXD_O(rxd),
    .INT_O(int_o), .INT_OE_N_O(int_n), .CLK_O(clko), .LINE_CONTROL_O(lc), .TONE_CONTROL_O(tc),
    .ANSWER_MODE_O(ans));
  mhp_host_model mhp_host_model_inst (.clk_i(clk), .bus_dev_i(bus_dev), .bus_oe_n_i(bus_oe_n), .ser_dev_i(ser_dev),
    .ser_oe_n_i(ser_oe_n), .serial_mode_o(serial_mode), .ale_o(ale), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .ext_clk_o(ext_clk), .bus_o(bus_lvl), .ser_o(ser_lvl), .got_stb_o(got_stb), .got_o(got));
  ////////////////////////////////////////
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic clear_ctl;
    shadow[0] = 8'h00;
    shadow[1] = 8'h00;
    shadow[3] = 8'h00;
  endtask : clear_ctl
  task automatic wr(input logic [2:0] a, input logic [7:0] v, input logic s);
    if (a == 3'h0 || a == 3'h1 || a == 3'h3) begin
      shadow[a] = v;
    end
    if (a == 3'h1 && v[HC_SRST_BIT]) begin
      clear_ctl();
    end
    if (s) begin
      mhp_host_model_inst.ser(1'b1, a, v);
    end else begin
      mhp_host_model_inst.par(1'b1, 1'b0, a, v);
    end
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic s);
    shadow[2] = {2'b00, det};
    exp_q.push_back({1'b0, shadow[a]});
    if (s) begin
      mhp_host_model_inst.ser(1'b0, a, 8'h00);
    end else begin
      mhp_host_model_inst.par(1'b0, 1'b0, a, 8'h00);
    end
  endtask : rd
  task automatic rd_all(input logic s);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), s);
    end
  endtask : rd_all
  task automatic half(output int h);
    logic v;
    int k;
    k = 0;
    v = clko;
    while (clko === v && k < 8000) begin
      @(negedge clk);
      k++;
    end
    v = clko;
    h = 0;
    while (clko === v && h < 8000) begin
      @(negedge clk);
      h++;
    end
  endtask : half
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (got_stb === 1'b1) begin
      mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      `CHK("read", mon_exp, got)
    end
  end
  always @(negedge clk) begin
    if (tx_stb === 1'b1) begin
      stb_cnt++;
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    d = 8'($urandom(32'h441e));
    for (int a = 0; a < 8; a++) begin
      shadow[a] = 8'h00;
    end
    shadow[6] = PART_CODE_VAL;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    det = 6'h25;
    rd_all(1'b0);
    `CHK("irq_idle", 1'b1, int_n)
    wr(3'h2, 8'hff, 1'b0);
    wr(3'h6, 8'h00, 1'b0);
    wr(3'h4, 8'hff, 1'b0);
    mhp_host_model_inst.par(1'b1, 1'b1, 3'h0, 8'h5c);
    exp_q.push_back(9'h100);
    mhp_host_model_inst.par(1'b0, 1'b1, 3'h6, 8'h00);
    rd_all(1'b0);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom()) & 8'hbf;
      t = 8'($urandom());
      wr(3'h0, d, i[0]);
      `CHK("line_control", d, lc)
      `CHK("answer_mode", ~d[0], ans)
      wr(3'h3, t, i[0]);
      `CHK("tone_control", t, tc)
      rd_all(i[0]);
    end
    wr(3'h1, 8'h20, 1'b0);
    det[1] = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("irq_set", 1'b0, int_n)
    `CHK("irq_level", 1'b0, int_o)
    rd(3'h2, 1'b0);
    `CHK("irq_clear", 1'b1, int_n)
    det[0] = ~det[0];
    repeat (4) @(negedge clk);
    `CHK("irq_long_loop", 1'b1, int_n)
    det[4] = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("irq_set_unscr", 1'b0, int_n)
    rd(3'h2, 1'b1);
    `CHK("irq_clear_ser", 1'b1, int_n)
    det[3] = 1'b1;
    rxcc = 1'b1;
    rxdd = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("rx_clock_on", 1'b1, rxc)
    rxcc = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("rx_clock_fall", 1'b0, rxc)
    `CHK("rx_data", 1'b0, rxd)
    det[3] = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("rx_clock_off", 1'b1, rxc)
    `CHK("rx_mark", 1'b1, rxd)
    wr(3'h0, 8'h08, 1'b0);
    wr(3'h1, 8'h08, 1'b0);
    half(n);
    `CHK("clk_rate16", BAUD16_HALF_CYC, n)
    txd = 1'b0;
    stb_cnt = 0;
    mhp_host_model_inst.ext_level(1'b0);
    `CHK("tx_clock_low", 1'b0, txc)
    mhp_host_model_inst.ext_level(1'b1);
    `CHK("tx_clock_high", 1'b1, txc)
    `CHK("tx_data", 1'b0, txo)
    `CHK("tx_strobes", 1, stb_cnt)
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    clear_ctl();
    repeat (2) @(negedge clk);
    `CHK("irq_reset", 1'b1, int_n)
    half(n);
    `CHK("clk_crystal", XTAL_HALF_CYC, n)
    rd_all(1'b0);
    wr(3'h0, 8'h91, 1'b1);
    wr(3'h3, 8'h3c, 1'b0);
    wr(3'h1, 8'h04, 1'b0);
    rd_all(1'b1);
    for (int k = 0; k < 20 && exp_q.size() > 0; k++) begin
      @(negedge clk);
    end
    `CHK("pending", 0, exp_q.size())
    print_verdict();
  end
endmodule : test_modem_host_register_port
